//--- shared/acqr_pkg.sv
// Shared constants and types for the acquisition result and filter control registers
package acqr_pkg;

   // ------------------------------------------------------------
   // Register offsets
   // ------------------------------------------------------------
   localparam logic [6:0] ACQR_OFF_CUR_HIGH   = 7'h00;
   localparam logic [6:0] ACQR_OFF_CUR_LOW    = 7'h01;
   localparam logic [6:0] ACQR_OFF_VOLT_HIGH  = 7'h02;
   localparam logic [6:0] ACQR_OFF_VOLT_LOW   = 7'h03;
   localparam logic [6:0] ACQR_OFF_FLAGS      = 7'h04;
   localparam logic [6:0] ACQR_OFF_FILT_CTRL  = 7'h05;

   // ------------------------------------------------------------
   // Reset values
   // ------------------------------------------------------------
   localparam logic [15:0] ACQR_RST_RESULT    = 16'h0000;
   localparam logic [7:0]  ACQR_RST_FLAGS     = 8'h00;
   localparam logic [7:0]  ACQR_RST_FILT_CTRL = 8'h45;
   localparam logic [7:0]  ACQR_UNMAPPED_READ = 8'h00;

   // ------------------------------------------------------------
   // Status bit positions
   // ------------------------------------------------------------
   localparam int ACQR_FLG_NORMAL_FIRST   = 7;
   localparam int ACQR_FLG_NORMAL_SECOND  = 6;
   localparam int ACQR_FLG_STANDBY_FIRST  = 5;
   localparam int ACQR_FLG_STANDBY_SECOND = 4;
   localparam int ACQR_FLG_SUPPLY_POR     = 3;
   localparam int ACQR_FLG_CUR_UPDATED    = 2;
   localparam int ACQR_FLG_VOLT_UPDATED   = 1;
   localparam int ACQR_FLG_RESERVED       = 0;

   // ------------------------------------------------------------
   // Filter control field positions
   // ------------------------------------------------------------
   localparam int ACQR_CTL_FIRST_128 = 7;
   localparam int ACQR_CTL_CHOP_HI   = 6;
   localparam int ACQR_CTL_CHOP_LO   = 5;
   localparam int ACQR_CTL_RATIO_HI  = 4;
   localparam int ACQR_CTL_RATIO_LO  = 1;
   localparam int ACQR_CTL_SAT_MASK  = 0;

   // ------------------------------------------------------------
   // Chopper division, in modulator clock ticks
   // ------------------------------------------------------------
   localparam logic [1:0]  ACQR_CHOP_HOLD    = 2'b00;
   localparam logic [1:0]  ACQR_CHOP_DIV_256 = 2'b01;
   localparam logic [1:0]  ACQR_CHOP_DIV_512 = 2'b10;
   localparam logic [10:0] ACQR_CHOP_256     = 11'd256;
   localparam logic [10:0] ACQR_CHOP_512     = 11'd512;
   localparam logic [10:0] ACQR_CHOP_1024    = 11'd1024;

   // ------------------------------------------------------------
   // Serial frame
   // ------------------------------------------------------------
   localparam logic [2:0]  ACQR_LAST_BIT     = 3'd7;
   localparam logic [15:0] ACQR_RATIO_ONE    = 16'h0001;

   typedef enum logic [1:0] {
      ACQR_PH_IDLE,
      ACQR_PH_CMD,
      ACQR_PH_DATA
   } acqr_phase_t;

   // ------------------------------------------------------------
   // Carriers
   // ------------------------------------------------------------
   typedef struct packed {
      logic        valid;
      logic [15:0] value;
   } acqr_result_t;

   typedef struct packed {
      logic normal_acq_first;
      logic normal_acq_second;
      logic standby_acq_first;
      logic standby_acq_second;
      logic analog_supply_por;
   } acqr_mode_flags_t;

   typedef struct packed {
      logic        first_stage_128;
      logic        sat_irq_mask;
      logic [15:0] second_stage_ratio;
      logic        chopper_clock;
   } acqr_filter_cfg_t;

   typedef struct packed {
      logic [2:0] stages;
      logic       level;
   } acqr_sync_t;

endpackage

//--- verilog/acqr_sync.sv
// Three-stage pin synchroniser that moves its level only when the last two stages agree
`timescale 1ns/100ps

module acqr_sync #(
   parameter logic RST_LEVEL = 1'b0
) (
   input  wire logic sys_clk,
   input  wire logic sys_rst,
   input  wire logic pin,
   output logic      level
);
   import acqr_pkg::*;

   acqr_sync_t s_q;
   acqr_sync_t s_d;

   always_comb begin
      s_d = s_q;
      s_d.stages = {s_q.stages[1:0], pin};
      // First stage feeds only the second, never the comparison
      if (s_q.stages[1] == s_q.stages[2]) begin
         s_d.level = s_q.stages[2];
      end
   end

   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         s_q <= '{stages: {3{RST_LEVEL}}, level: RST_LEVEL};
      end else begin
         s_q <= s_d;
      end
   end

   assign level = s_q.level;

endmodule

//--- verilog/acqr_regs.sv
// Result, status and current-path filter control registers behind a serial slave port
`timescale 1ns/100ps

module acqr_regs (
   input  wire logic                      sys_clk,
   input  wire logic                      sys_rst,
   input  wire logic                      spi_cs_n,
   input  wire logic                      spi_sclk,
   input  wire logic                      spi_sdi,
   output logic                           spi_sdo_o,
   output logic                           spi_sdo_oe,
   input  wire acqr_pkg::acqr_result_t    current_result,
   input  wire acqr_pkg::acqr_result_t    voltage_result,
   input  wire acqr_pkg::acqr_mode_flags_t mode_flags,
   input  wire logic                      modulator_clock,
   output acqr_pkg::acqr_filter_cfg_t     filter_cfg
);
   import acqr_pkg::*;

   // ------------------------------------------------------------
   // State
   // ------------------------------------------------------------
   typedef struct packed {
      logic [15:0]  cur;
      logic [15:0]  volt;
      logic [7:0]   flags;
      logic [7:0]   ctrl;
      acqr_phase_t  phase;
      logic         cs_q;
      logic         sclk_q;
      logic         idle_high;
      logic [2:0]   bitcnt;
      logic [7:0]   rx;
      logic [7:0]   tx;
      logic [6:0]   addr;
      logic         is_read;
      logic         sdo;
      logic         sdo_oe;
      logic [9:0]   chop_cnt;
      logic         chop;
      logic [15:0]  ratio;
   } acqr_state_t;

   acqr_state_t s_q;
   acqr_state_t s_d;

   logic cs_f;
   logic sclk_f;
   logic sdi_f;

   // ------------------------------------------------------------
   // Pin synchronisers
   // ------------------------------------------------------------
   acqr_sync #(.RST_LEVEL(1'b1)) u_sync_cs (
      .sys_clk (sys_clk),
      .sys_rst (sys_rst),
      .pin     (spi_cs_n),
      .level   (cs_f)
   );

   acqr_sync #(.RST_LEVEL(1'b0)) u_sync_sclk (
      .sys_clk (sys_clk),
      .sys_rst (sys_rst),
      .pin     (spi_sclk),
      .level   (sclk_f)
   );

   acqr_sync #(.RST_LEVEL(1'b0)) u_sync_sdi (
      .sys_clk (sys_clk),
      .sys_rst (sys_rst),
      .pin     (spi_sdi),
      .level   (sdi_f)
   );

   // ------------------------------------------------------------
   // Read multiplexer
   // ------------------------------------------------------------
   function automatic logic [7:0] rd_byte(input logic [6:0] a, input acqr_state_t s);
      logic [7:0] v;
      v = ACQR_UNMAPPED_READ;
      case (a)
         ACQR_OFF_CUR_HIGH:  v = s.cur[15:8];
         ACQR_OFF_CUR_LOW:   v = s.cur[7:0];
         ACQR_OFF_VOLT_HIGH: v = s.volt[15:8];
         ACQR_OFF_VOLT_LOW:  v = s.volt[7:0];
         ACQR_OFF_FLAGS:     v = s.flags;
         ACQR_OFF_FILT_CTRL: v = s.ctrl;
         default:            v = ACQR_UNMAPPED_READ;
      endcase
      return v;
   endfunction

   // ------------------------------------------------------------
   // Next state
   // ------------------------------------------------------------
   always_comb begin
      logic       cs_fall;
      logic       sclk_rise;
      logic       sclk_fall;
      logic       sample;
      logic       shift;
      logic       byte_done;
      logic       flag_clear;
      logic [7:0] rx_n;
      logic [6:0] a;
      logic [10:0] half;
      cs_fall    = 1'b0;
      sclk_rise  = 1'b0;
      sclk_fall  = 1'b0;
      sample     = 1'b0;
      shift      = 1'b0;
      byte_done  = 1'b0;
      flag_clear = 1'b0;
      rx_n       = 8'h00;
      a          = 7'h00;
      half       = 11'h000;

      s_d        = s_q;
      s_d.cs_q   = cs_f;
      s_d.sclk_q = sclk_f;

      cs_fall   = s_q.cs_q & ~cs_f;
      sclk_rise = ~s_q.sclk_q & sclk_f;
      sclk_fall = s_q.sclk_q & ~sclk_f;
      // Clock level at select decides which edge samples and which shifts
      sample    = s_q.idle_high ? sclk_rise : sclk_fall;
      shift     = s_q.idle_high ? sclk_fall : sclk_rise;

      // Results are latched whole so both bytes always belong together
      if (current_result.valid) begin
         s_d.cur = current_result.value;
      end
      if (voltage_result.valid) begin
         s_d.volt = voltage_result.value;
      end

      // ---------------- serial slave ----------------
      case (s_q.phase)
         ACQR_PH_IDLE: begin
            s_d.sdo_oe = 1'b0;
            if (cs_fall) begin
               s_d.phase     = ACQR_PH_CMD;
               s_d.idle_high = sclk_f;
               s_d.bitcnt    = 3'd0;
               s_d.is_read   = 1'b0;
            end
         end
         ACQR_PH_CMD, ACQR_PH_DATA: begin
            if (cs_f) begin
               s_d.phase  = ACQR_PH_IDLE;
               s_d.sdo_oe = 1'b0;
            end else begin
               if (shift && s_q.is_read && s_q.phase == ACQR_PH_DATA) begin
                  s_d.sdo    = s_q.tx[7];
                  s_d.tx     = {s_q.tx[6:0], 1'b0};
                  s_d.sdo_oe = 1'b1;
               end
               if (sample) begin
                  rx_n       = {s_q.rx[6:0], sdi_f};
                  s_d.rx     = rx_n;
                  s_d.bitcnt = s_q.bitcnt + 3'd1;
                  byte_done  = (s_q.bitcnt == ACQR_LAST_BIT);
               end
               if (byte_done && s_q.phase == ACQR_PH_CMD) begin
                  a           = rx_n[6:0];
                  s_d.is_read = rx_n[7];
                  s_d.phase   = ACQR_PH_DATA;
                  if (rx_n[7]) begin
                     s_d.tx     = rd_byte(a, s_q);
                     flag_clear = (a == ACQR_OFF_FLAGS);
                     s_d.addr   = a + 7'd1;
                  end else begin
                     s_d.addr   = a;
                  end
               end else if (byte_done) begin
                  // Consecutive bytes walk the address upward
                  s_d.addr = s_q.addr + 7'd1;
                  if (s_q.is_read) begin
                     s_d.tx     = rd_byte(s_q.addr, s_q);
                     flag_clear = (s_q.addr == ACQR_OFF_FLAGS);
                  end else if (s_q.addr == ACQR_OFF_FILT_CTRL) begin
                     s_d.ctrl = rx_n;
                  end
               end
            end
         end
         default: begin
            s_d.phase  = ACQR_PH_IDLE;
            s_d.sdo_oe = 1'b0;
         end
      endcase

      // ---------------- status ----------------
      s_d.flags[ACQR_FLG_NORMAL_FIRST]   = mode_flags.normal_acq_first;
      s_d.flags[ACQR_FLG_NORMAL_SECOND]  = mode_flags.normal_acq_second;
      s_d.flags[ACQR_FLG_STANDBY_FIRST]  = mode_flags.standby_acq_first;
      s_d.flags[ACQR_FLG_STANDBY_SECOND] = mode_flags.standby_acq_second;
      s_d.flags[ACQR_FLG_SUPPLY_POR]     = mode_flags.analog_supply_por;
      s_d.flags[ACQR_FLG_RESERVED]       = 1'b0;
      if (flag_clear) begin
         s_d.flags[ACQR_FLG_CUR_UPDATED]  = 1'b0;
         s_d.flags[ACQR_FLG_VOLT_UPDATED] = 1'b0;
      end
      // Set after clear so an update during a status read is kept
      if (current_result.valid) begin
         s_d.flags[ACQR_FLG_CUR_UPDATED] = 1'b1;
      end
      if (voltage_result.valid) begin
         s_d.flags[ACQR_FLG_VOLT_UPDATED] = 1'b1;
      end

      // ---------------- filter controls ----------------
      s_d.ratio = ACQR_RATIO_ONE << s_d.ctrl[ACQR_CTL_RATIO_HI:ACQR_CTL_RATIO_LO];

      // Chopper toggles every half period counted in modulator ticks
      case (s_d.ctrl[ACQR_CTL_CHOP_HI:ACQR_CTL_CHOP_LO])
         ACQR_CHOP_DIV_256: half = ACQR_CHOP_256 >> 1;
         ACQR_CHOP_DIV_512: half = ACQR_CHOP_512 >> 1;
         default:           half = ACQR_CHOP_1024 >> 1;
      endcase
      if (s_d.ctrl[ACQR_CTL_CHOP_HI:ACQR_CTL_CHOP_LO] == ACQR_CHOP_HOLD) begin
         s_d.chop     = 1'b1;
         s_d.chop_cnt = 10'd0;
      end else if (modulator_clock) begin
         // Greater-or-equal lets a shorter divider take over cleanly mid-count
         if ({1'b0, s_q.chop_cnt} >= half - 11'd1) begin
            s_d.chop_cnt = 10'd0;
            s_d.chop     = ~s_q.chop;
         end else begin
            s_d.chop_cnt = s_q.chop_cnt + 10'd1;
         end
      end
   end

   // ------------------------------------------------------------
   // Registers
   // ------------------------------------------------------------
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         s_q           <= '0;
         s_q.cur       <= ACQR_RST_RESULT;
         s_q.volt      <= ACQR_RST_RESULT;
         s_q.flags     <= ACQR_RST_FLAGS;
         s_q.ctrl      <= ACQR_RST_FILT_CTRL;
         s_q.phase     <= ACQR_PH_IDLE;
         s_q.cs_q      <= 1'b1;
         s_q.chop      <= 1'b1;
         s_q.ratio     <= ACQR_RATIO_ONE << ACQR_RST_FILT_CTRL[ACQR_CTL_RATIO_HI:ACQR_CTL_RATIO_LO];
      end else begin
         s_q <= s_d;
      end
   end

   // ------------------------------------------------------------
   // Outputs
   // ------------------------------------------------------------
   assign spi_sdo_o                     = s_q.sdo;
   assign spi_sdo_oe                    = s_q.sdo_oe;
   assign filter_cfg.first_stage_128    = s_q.ctrl[ACQR_CTL_FIRST_128];
   assign filter_cfg.sat_irq_mask       = s_q.ctrl[ACQR_CTL_SAT_MASK];
   assign filter_cfg.second_stage_ratio = s_q.ratio;
   assign filter_cfg.chopper_clock      = s_q.chop;

endmodule

//--- testbench/acqr_regs_checker.sv
// Port assertions for the acquisition register block
`timescale 1ns/100ps
module acqr_regs_checker (
   input wire logic                       sys_clk,
   input wire logic                       sys_rst,
   input wire logic                       spi_cs_n,
   input wire logic                       spi_sclk,
   input wire logic                       spi_sdi,
   input wire logic                       spi_sdo_o,
   input wire logic                       spi_sdo_oe,
   input wire acqr_pkg::acqr_result_t     current_result,
   input wire acqr_pkg::acqr_result_t     voltage_result,
   input wire acqr_pkg::acqr_mode_flags_t mode_flags,
   input wire logic                       modulator_clock,
   input wire acqr_pkg::acqr_filter_cfg_t filter_cfg
);
   import acqr_pkg::*;
   default clocking dc @(posedge sys_clk); endclocking
   default disable iff (sys_rst);
   // Chip select seen high long enough to pass the synchronisers
   sequence cs_idle_s;
      spi_cs_n [*8];
   endsequence
   sequence chop_move_s;
      cs_idle_s ##1 $changed(filter_cfg.chopper_clock);
   endsequence
   chk_reset_cfg:
   assert property ($fell(sys_rst) |-> filter_cfg.sat_irq_mask && !filter_cfg.first_stage_128
      && filter_cfg.second_stage_ratio == 16'h0004 && filter_cfg.chopper_clock && !spi_sdo_oe)
      else $error("control defaults wrong after reset");
   chk_ratio_pow:
   assert property ($onehot(filter_cfg.second_stage_ratio))
      else $error("second stage ratio not a power of two");
   chk_cfg_quiet:
   assert property (cs_idle_s |=> $stable({filter_cfg.first_stage_128, filter_cfg.sat_irq_mask,
      filter_cfg.second_stage_ratio})) else $error("control changed without a frame");
   chk_chop_tick:
   assert property (chop_move_s |-> $past(modulator_clock, 1) || $past(modulator_clock, 2))
      else $error("chopper moved without a modulator tick");
   chk_sdo_edge:
   assert property (spi_sdo_oe && $past(spi_sdo_oe) && $changed(spi_sdo_o)
      |-> $past(spi_sclk, 3) != $past(spi_sclk, 8)) else $error("data out moved off a clock edge");
   chk_oe_frame:
   assert property (spi_sdo_oe |-> !$past(spi_cs_n, 8))
      else $error("data out driven outside a frame");
   chk_oe_drop:
   assert property ($rose(spi_cs_n) |-> ##[1:8] !spi_sdo_oe)
      else $error("data out not released after frame");
   chk_oe_idle:
   assert property (cs_idle_s |-> !spi_sdo_oe) else $error("data out driven while idle");
endmodule
bind acqr_regs acqr_regs_checker acqr_regs_checker_inst (
   .sys_clk(sys_clk), .sys_rst(sys_rst), .spi_cs_n(spi_cs_n), .spi_sclk(spi_sclk),
   .spi_sdi(spi_sdi), .spi_sdo_o(spi_sdo_o), .spi_sdo_oe(spi_sdo_oe),
   .current_result(current_result), .voltage_result(voltage_result),
   .mode_flags(mode_flags), .modulator_clock(modulator_clock), .filter_cfg(filter_cfg)
);

//--- testbench/acqr_spi_master.sv
// Serial bus master model that frames register reads and writes
`timescale 1ns/100ps
module acqr_spi_master (
   input  wire logic sys_clk,
   input  wire logic spi_sdo_o,
   input  wire logic spi_sdo_oe,
   output logic      spi_cs_n,
   output logic      spi_sclk,
   output logic      spi_sdi
);
   logic [7:0] data_buf [8];
   initial begin
      spi_cs_n = 1'b1;
      spi_sclk = 1'b1;
      spi_sdi = 1'b0;
   end
   task automatic wait_clk(input int n);
      repeat (n) @(posedge sys_clk);
   endtask
   // Half bit of 8 cycles: slow enough for the 3-flop pin synchronisers
   task automatic xfer(input logic idle, input logic rd, input logic [6:0] addr, input int n);
      logic [7:0] sh;
      spi_sclk <= idle;
      wait_clk(8);
      spi_cs_n <= 1'b0;
      wait_clk(8);
      for (int b = 0; b <= n; b++) begin
         sh = (b == 0) ? {rd, addr} : (rd ? 8'h00 : data_buf[b-1]);
         for (int i = 7; i >= 0; i--) begin
            spi_sclk <= ~idle;
            spi_sdi <= sh[i];
            wait_clk(8);
            spi_sclk <= idle;
            if (b > 0 && rd) data_buf[b-1][i] = spi_sdo_o;
            wait_clk(8);
         end
      end
      spi_cs_n <= 1'b1;
      spi_sdi <= ~spi_sdi;
      wait_clk(8);
   endtask
endmodule

//--- testbench/tb_acqr_regs.sv
// Self-checking bench for the acquisition register block
`timescale 1ns/100ps
module tb_acqr_regs;
   import acqr_pkg::*;
   logic             sys_clk, sys_rst, spi_cs_n, spi_sclk, spi_sdi;
   logic             spi_sdo_o, spi_sdo_oe, modulator_clock;
   acqr_result_t     current_result, voltage_result;
   acqr_mode_flags_t mode_flags;
   acqr_filter_cfg_t filter_cfg;
   int               error_cnt, compares, cyc, n;
   acqr_regs acqr_regs_inst (.sys_clk(sys_clk), .sys_rst(sys_rst), .spi_cs_n(spi_cs_n),
      .spi_sclk(spi_sclk), .spi_sdi(spi_sdi), .spi_sdo_o(spi_sdo_o), .spi_sdo_oe(spi_sdo_oe),
      .current_result(current_result), .voltage_result(voltage_result),
      .mode_flags(mode_flags), .modulator_clock(modulator_clock), .filter_cfg(filter_cfg));
   acqr_spi_master acqr_spi_master_inst (.sys_clk(sys_clk), .spi_sdo_o(spi_sdo_o),
      .spi_sdo_oe(spi_sdo_oe), .spi_cs_n(spi_cs_n), .spi_sclk(spi_sclk), .spi_sdi(spi_sdi));
   initial begin
      sys_clk = 1'b0;
      forever #5 sys_clk = ~sys_clk;
   end
   // Modulator tick every fourth cycle; ceiling well above the expected run
   always @(posedge sys_clk) begin
      cyc <= cyc + 1;
      modulator_clock <= (cyc[1:0] == 2'b11);
      if (cyc == 60000) begin
         error_cnt++;
         finish_test();
      end
   end
   task automatic finish_test();
      $display("compares %0d mismatches %0d", compares, error_cnt);
      if (error_cnt == 0 && compares > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
      compares++;
      if (got !== exp) begin
         error_cnt++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic rd_chk(input logic idle, input logic [6:0] a, input int k, input logic [63:0] e);
      acqr_spi_master_inst.xfer(idle, 1'b1, a, k);
      for (int i = 0; i < k; i++)
         chk("read byte", {8'h00, e[8*(k-1-i) +: 8]}, {8'h00, acqr_spi_master_inst.data_buf[i]});
   endtask
   task automatic wr(input logic idle, input logic [6:0] a, input logic [7:0] d);
      acqr_spi_master_inst.data_buf[0] = d;
      acqr_spi_master_inst.xfer(idle, 1'b0, a, 1);
   endtask
   task automatic t_defaults();
      rd_chk(1'b1, ACQR_OFF_CUR_HIGH, 6, 64'h0000_0000_0045);
      chk("ratio", 16'h0004, filter_cfg.second_stage_ratio);
      $display("defaults test done");
   endtask
   task automatic t_results();
      current_result <= {1'b1, 16'ha5c3};
      voltage_result <= {1'b1, 16'h3c5a};
      mode_flags <= 5'b10110;
      @(posedge sys_clk);
      current_result.valid <= 1'b0;
      voltage_result.valid <= 1'b0;
      rd_chk(1'b0, ACQR_OFF_CUR_HIGH, 5, 64'ha5c3_3c5a_b6);
      mode_flags <= 5'b01001;
      rd_chk(1'b0, ACQR_OFF_FLAGS, 1, 64'h48);
      voltage_result <= {1'b1, 16'h1234};
      @(posedge sys_clk);
      voltage_result.valid <= 1'b0;
      rd_chk(1'b1, ACQR_OFF_CUR_HIGH, 5, 64'ha5c3_1234_4a);
      $display("results test done");
   endtask
   task automatic t_refused();
      wr(1'b1, ACQR_OFF_CUR_HIGH, 8'hff);
      rd_chk(1'b1, ACQR_OFF_CUR_HIGH, 1, 64'ha5);
      rd_chk(1'b1, 7'h10, 1, 64'h00);
      $display("refused test done");
   endtask
   task automatic t_ratio();
      for (int c = 0; c < 16; c++) begin
         wr(c[0], ACQR_OFF_FILT_CTRL, {1'b1, 2'b00, c[3:0], 1'b0});
         chk("ratio", 16'h0001 << c, filter_cfg.second_stage_ratio);
         chk("first stage", 16'h0001, {15'h0000, filter_cfg.first_stage_128});
         chk("sat mask", 16'h0000, {15'h0000, filter_cfg.sat_irq_mask});
      end
      acqr_spi_master_inst.wait_clk(600);
      chk("chopper hold", 16'h0001, {15'h0000, filter_cfg.chopper_clock});
      wr(1'b1, ACQR_OFF_FILT_CTRL, 8'h45);
      rd_chk(1'b0, ACQR_OFF_FILT_CTRL, 1, 64'h45);
      $display("ratio test done");
   endtask
   // Skips the first toggle so a counter left mid-count across the write does not skew it
   task automatic t_chopper();
      logic last;
      for (int k = 1; k < 4; k++) begin
         wr(1'b1, ACQR_OFF_FILT_CTRL, {1'b0, k[1:0], 4'b0010, 1'b1});
         for (int j = 0; j < 2; j++) begin
            last = filter_cfg.chopper_clock;
            n = 0;
            while (n < 5000 && filter_cfg.chopper_clock === last) begin
               @(posedge sys_clk);
               n++;
            end
         end
         chk("chopper period", 16'h0100 << k, n[15:0]);
      end
      $display("chopper test done");
   endtask
   initial begin
      sys_rst = 1'b1;
      current_result = '0;
      voltage_result = '0;
      mode_flags = '0;
      modulator_clock = 1'b0;
      cyc = 0;
      error_cnt = 0;
      compares = 0;
      repeat (4) @(posedge sys_clk);
      sys_rst <= 1'b0;
      repeat (4) @(posedge sys_clk);
      t_defaults();
      t_results();
      t_refused();
      t_ratio();
      t_chopper();
      finish_test();
   end
endmodule
